// ==== hdl/cogtb_bank.sv ====
// Per-core offset and fine-gain trim bank behind the serial register port.
// Assumes the serial port pins are asynchronous and SCLK is at most one eighth of clock.
`timescale 1ns/1ps
`include "cogtb_regs.svh"
module cogtb_bank (
   // Clock and reset.
   input wire logic clock,
   input wire logic reset_n,
   // Serial register port.
   input wire logic spi_sclk,
   input wire logic spi_cs_n,
   input wire logic spi_sdi,
   output logic spi_sdo,
   output logic spi_sdo_oe_n,
   // Conversion status from the cores.
   input wire logic core3_input_d_sel,
   input wire logic core2_input_a_sel,
   // Fuse defaults.
   input wire logic [`COGTB_OFFSET_W-1:0] fuse_core3_input_c_offset,
   input wire logic [`COGTB_OFFSET_W-1:0] fuse_core3_input_d_offset,
   input wire logic [`COGTB_OFFSET_W-1:0] fuse_core4_offset,
   input wire logic [`COGTB_OFFSET_W-1:0] fuse_core5_offset,
   input wire logic [`COGTB_GAIN_W-1:0] fuse_core0_gain,
   input wire logic [`COGTB_GAIN_W-1:0] fuse_core1_gain,
   input wire logic [`COGTB_GAIN_W-1:0] fuse_core2_input_a_gain,
   // Corrections applied to the cores, and the index of the last written byte.
   output logic [`COGTB_OFFSET_W-1:0] core3_offset,
   output logic [`COGTB_OFFSET_W-1:0] core4_offset,
   output logic [`COGTB_OFFSET_W-1:0] core5_offset,
   output logic [`COGTB_GAIN_W-1:0] core0_gain,
   output logic [`COGTB_GAIN_W-1:0] core1_gain,
   output logic [`COGTB_GAIN_W-1:0] core2_gain,
   output cogtb_pkg::cogtb_idx_t last_idx,
   output logic core2_gain_valid
);
   import cogtb_pkg::*;
   localparam int DEPTH = `COGTB_DEPTH;
   localparam int OW = `COGTB_OFFSET_W;
   localparam int GW = `COGTB_GAIN_W;

   logic cs_q1, cs_q2, sclk_q1, sclk_q2, sclk_q3, sdi_q1, sdi_q2;
   logic rise, fall, fuse_load;
   cogtb_state_t state, next_state;
   logic [4:0] bit_cnt, next_bit_cnt;
   logic [14:0] cmd_sh, next_cmd_sh, addr, next_addr;
   logic [6:0] data_sh, next_data_sh;
   logic is_read, next_is_read;
   logic wr_en, rd_en, rd_valid;
   cogtb_idx_t wr_idx, rd_idx, next_last_idx;
   logic [7:0] wr_data, rd_data, out_sh, next_out_sh;
   logic next_sdo, next_sdo_oe_n;
   logic [DEPTH*8-1:0] image, fuse_image;
   logic [OW-1:0] ofs_c, ofs_d, ofs_4, ofs_5;
   logic [OW-1:0] next_core3_offset;
   logic [GW-1:0] next_core2_gain;

   function automatic cogtb_idx_t dec_idx(input logic [14:0] a);
      logic [14:0] rel;
      rel = 15'h0000;
      if (a >= `COGTB_ADR_CORE3_INPUT_C_OFFSET_TRIM && a <= `COGTB_ADR_OFFSET_LAST) begin
         rel = a - `COGTB_ADR_CORE3_INPUT_C_OFFSET_TRIM;
         return cogtb_idx_t'(rel);
      end
      if (a >= `COGTB_ADR_CORE0_FINE_GAIN_TRIM &&
          a <= `COGTB_ADR_CORE2_INPUT_A_FINE_GAIN_TRIM) begin
         rel = a - `COGTB_ADR_CORE0_FINE_GAIN_TRIM + 15'(`COGTB_OFFSET_BYTES);
         return cogtb_idx_t'(rel);
      end
      return `COGTB_IDX_NONE;
   endfunction : dec_idx

   // Reserved bits are not stored, so they always read back as zero.
   function automatic logic [7:0] idx_mask(input cogtb_idx_t i);
      if (32'(i) >= `COGTB_OFFSET_BYTES) begin
         return `COGTB_MASK_GAIN;
      end
      return i[0] ? `COGTB_MASK_OFFSET_HI : `COGTB_MASK_OFFSET_LO;
   endfunction : idx_mask

   // Pins cross into the clock domain through two flops each.
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         cs_q1 <= 1'b1;
         cs_q2 <= 1'b1;
         sclk_q1 <= 1'b0;
         sclk_q2 <= 1'b0;
         sclk_q3 <= 1'b0;
         sdi_q1 <= 1'b0;
         sdi_q2 <= 1'b0;
         fuse_load <= 1'b1;
      end else begin
         cs_q1 <= spi_cs_n;
         cs_q2 <= cs_q1;
         sclk_q1 <= spi_sclk;
         sclk_q2 <= sclk_q1;
         sclk_q3 <= sclk_q2;
         sdi_q1 <= spi_sdi;
         sdi_q2 <= sdi_q1;
         fuse_load <= 1'b0;
      end
   end
   assign rise = sclk_q2 && !sclk_q3;
   assign fall = !sclk_q2 && sclk_q3;

   // Frame: one read flag, fifteen address bits, then bytes with address increment.
   always_comb begin
      next_state = state;
      next_bit_cnt = bit_cnt;
      next_cmd_sh = cmd_sh;
      next_addr = addr;
      next_data_sh = data_sh;
      next_is_read = is_read;
      next_last_idx = last_idx;
      wr_en = 1'b0;
      wr_idx = dec_idx(addr);
      wr_data = 8'h00;
      rd_en = 1'b0;
      rd_idx = `COGTB_IDX_NONE;
      case (state)
         st_idle: begin
            next_bit_cnt = 5'h00;
            if (!cs_q2) begin
               next_state = st_cmd;
            end
         end
         st_cmd: begin
            if (rise) begin
               next_cmd_sh = {cmd_sh[13:0], sdi_q2};
               next_bit_cnt = bit_cnt + 5'h01;
               if (bit_cnt == `COGTB_CMD_BITS) begin
                  next_is_read = cmd_sh[14];
                  next_addr = {cmd_sh[13:0], sdi_q2};
                  next_bit_cnt = 5'h00;
                  next_state = st_data;
                  rd_en = cmd_sh[14];
                  rd_idx = dec_idx({cmd_sh[13:0], sdi_q2});
               end
            end
         end
         st_data: begin
            if (rise) begin
               next_data_sh = {data_sh[5:0], sdi_q2};
               next_bit_cnt = bit_cnt + 5'h01;
               if (bit_cnt == `COGTB_BYTE_BITS) begin
                  next_bit_cnt = 5'h00;
                  next_addr = addr + 15'h0001;
                  // Unmapped addresses drop the write; the store holds no entry there.
                  wr_en = !is_read && (32'(wr_idx) < DEPTH);
                  wr_data = {data_sh, sdi_q2} & idx_mask(wr_idx);
                  if (wr_en) begin
                     next_last_idx = wr_idx;
                  end
                  rd_en = is_read;
                  rd_idx = dec_idx(addr + 15'h0001);
               end
            end
         end
         default: next_state = st_idle;
      endcase
      if (cs_q2) begin
         next_state = st_idle;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         state <= st_idle;
         bit_cnt <= 5'h00;
         cmd_sh <= 15'h0000;
         addr <= 15'h0000;
         data_sh <= 7'h00;
         is_read <= 1'b0;
         last_idx <= `COGTB_IDX_NONE;
      end else begin
         state <= next_state;
         bit_cnt <= next_bit_cnt;
         cmd_sh <= next_cmd_sh;
         addr <= next_addr;
         data_sh <= next_data_sh;
         is_read <= next_is_read;
         last_idx <= next_last_idx;
      end
   end

   // Read data launch on falling SCLK; the fetched byte must land before that edge.
   always_comb begin
      next_out_sh = out_sh;
      next_sdo = spi_sdo;
      next_sdo_oe_n = !(state == st_data && is_read && !cs_q2);
      if (rd_valid) begin
         next_out_sh = rd_data;
      end else if (fall && state == st_data && is_read) begin
         next_sdo = out_sh[7];
         next_out_sh = {out_sh[6:0], 1'b0};
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         out_sh <= 8'h00;
         spi_sdo <= 1'b0;
         spi_sdo_oe_n <= 1'b1;
      end else begin
         out_sh <= next_out_sh;
         spi_sdo <= next_sdo;
         spi_sdo_oe_n <= next_sdo_oe_n;
      end
   end

   // Fuse image laid out like the register bytes.
   assign fuse_image = {8'(fuse_core2_input_a_gain), 8'(fuse_core1_gain), 8'(fuse_core0_gain),
                        16'(fuse_core5_offset), 16'(fuse_core4_offset),
                        16'(fuse_core3_input_d_offset), 16'(fuse_core3_input_c_offset)};

   cogtb_store #(.DEPTH(DEPTH)) u_store (
      .clock(clock),
      .reset_n(reset_n),
      .load_en(fuse_load),
      .load_image(fuse_image),
      .wr_en(wr_en),
      .wr_idx(wr_idx),
      .wr_data(wr_data),
      .rd_en(rd_en),
      .rd_idx(rd_idx),
      .rd_data(rd_data),
      .rd_valid(rd_valid),
      .image(image)
   );

   // Offsets are plain unsigned codes, never sign extended.
   assign ofs_c = image[`COGTB_IDX_C3C*8 +: OW];
   assign ofs_d = image[`COGTB_IDX_C3D*8 +: OW];
   assign ofs_4 = image[`COGTB_IDX_C4*8 +: OW];
   assign ofs_5 = image[`COGTB_IDX_C5*8 +: OW];

   always_comb begin
      next_core3_offset = core3_input_d_sel ? ofs_d : ofs_c;
      next_core2_gain = core2_input_a_sel ? image[`COGTB_IDX_G2A*8 +: GW] : '0;
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         core3_offset <= '0;
         core4_offset <= '0;
         core5_offset <= '0;
         core0_gain <= '0;
         core1_gain <= '0;
         core2_gain <= '0;
         core2_gain_valid <= 1'b0;
      end else begin
         core3_offset <= next_core3_offset;
         core4_offset <= ofs_4;
         core5_offset <= ofs_5;
         core0_gain <= image[`COGTB_IDX_G0*8 +: GW];
         core1_gain <= image[`COGTB_IDX_G1*8 +: GW];
         core2_gain <= next_core2_gain;
         core2_gain_valid <= core2_input_a_sel;
      end
   end

   sequence s_byte_done;
      state == st_data && rise && bit_cnt == `COGTB_BYTE_BITS && !is_read && !cs_q2;
   endsequence
   sequence s_core4_lo_write;
      wr_en && wr_idx == cogtb_idx_t'(`COGTB_IDX_C4) && !fuse_load;
   endsequence

   AST_C_INPUT: assert property (@(posedge clock) disable iff (!reset_n)
      !core3_input_d_sel |=> core3_offset == $past(ofs_c))
      else $error("core 3 input C offset not applied");
   AST_D_INPUT: assert property (@(posedge clock) disable iff (!reset_n)
      core3_input_d_sel |=> core3_offset == $past(ofs_d))
      else $error("core 3 input D offset not applied");
   AST_CORE4: assert property (@(posedge clock) disable iff (!reset_n)
      ##1 core4_offset == $past(ofs_4))
      else $error("core 4 offset not applied");
   AST_CORE5: assert property (@(posedge clock) disable iff (!reset_n)
      ##1 core5_offset == $past(ofs_5))
      else $error("core 5 offset not applied");
   AST_GAIN01: assert property (@(posedge clock) disable iff (!reset_n)
      ##1 core0_gain == $past(image[`COGTB_IDX_G0*8 +: GW]) &&
      core1_gain == $past(image[`COGTB_IDX_G1*8 +: GW]))
      else $error("core 0 or 1 gain not applied");
   AST_GAIN2_A_ONLY: assert property (@(posedge clock) disable iff (!reset_n)
      !core2_input_a_sel |=> !core2_gain_valid && core2_gain == '0)
      else $error("core 2 gain applied outside input A");
   AST_FUSE_LOAD: assert property (@(posedge clock) disable iff (!reset_n)
      fuse_load && reset_n |=> ##1 core4_offset == $past(fuse_core4_offset, 2))
      else $error("fuse default not loaded");
   AST_WRITE_EFFECT: assert property (@(posedge clock) disable iff (!reset_n)
      s_core4_lo_write |=> ##1 core4_offset[7:0] == $past(wr_data, 2))
      else $error("written trim not applied two cycles later");
   AST_WRITE_STROBE: assert property (@(posedge clock) disable iff (!reset_n)
      s_byte_done |-> wr_en == ((addr >= `COGTB_ADR_CORE3_INPUT_C_OFFSET_TRIM &&
      addr <= `COGTB_ADR_OFFSET_LAST) || (addr >= `COGTB_ADR_CORE0_FINE_GAIN_TRIM &&
      addr <= `COGTB_ADR_CORE2_INPUT_A_FINE_GAIN_TRIM)))
      else $error("completed byte did not write a mapped trim");
   AST_RESERVED_ZERO: assert property (@(posedge clock) disable iff (!reset_n)
      wr_en && wr_idx[0] && 32'(wr_idx) < `COGTB_OFFSET_BYTES |-> wr_data[7:4] == 4'h0)
      else $error("reserved offset bits stored");
endmodule : cogtb_bank

// ==== hdl/cogtb_regs.svh ====
// Register addresses, field positions and reset values of the trim bank.
// Assumes byte addressing on the serial port, low byte of a 16-bit register at its base.
`ifndef COGTB_REGS_SVH
`define COGTB_REGS_SVH
`define COGTB_ADDR_W 15
`define COGTB_ADR_CORE3_INPUT_C_OFFSET_TRIM 15'h0338
`define COGTB_ADR_CORE3_INPUT_D_OFFSET_TRIM 15'h033A
`define COGTB_ADR_CORE4_OFFSET_TRIM 15'h033C
`define COGTB_ADR_CORE5_OFFSET_TRIM 15'h033E
`define COGTB_ADR_OFFSET_LAST 15'h033F
`define COGTB_ADR_CORE0_FINE_GAIN_TRIM 15'h0360
`define COGTB_ADR_CORE1_FINE_GAIN_TRIM 15'h0361
`define COGTB_ADR_CORE2_INPUT_A_FINE_GAIN_TRIM 15'h0362
`define COGTB_OFFSET_W 12
`define COGTB_GAIN_W 5
`define COGTB_OFFSET_BYTES 8
`define COGTB_DEPTH 11
`define COGTB_IDX_NONE 4'hF
`define COGTB_IDX_C3C 0
`define COGTB_IDX_C3D 2
`define COGTB_IDX_C4 4
`define COGTB_IDX_C5 6
`define COGTB_IDX_G0 8
`define COGTB_IDX_G1 9
`define COGTB_IDX_G2A 10
`define COGTB_MASK_OFFSET_LO 8'hFF
`define COGTB_MASK_OFFSET_HI 8'h0F
`define COGTB_MASK_GAIN 8'h1F
`define COGTB_RESET_BYTE 8'h00
`define COGTB_CMD_BITS 5'h0F
`define COGTB_BYTE_BITS 5'h07
`endif

// ==== hdl/cogtb_pkg.sv ====
// Types shared by the trim bank and its storage.
// Assumes nothing beyond a SystemVerilog compiler.
package cogtb_pkg;
   typedef logic [3:0] cogtb_idx_t;
   typedef enum logic [1:0] {
      st_idle = 2'b00,
      st_cmd = 2'b01,
      st_data = 2'b10
   } cogtb_state_t;
endpackage : cogtb_pkg

// ==== hdl/cogtb_store.sv ====
// Byte storage of the trim registers with a registered read port.
// Assumes writes arrive already masked and decoded by the bank.
`timescale 1ns/1ps
`include "cogtb_regs.svh"
module cogtb_store #(
   parameter int DEPTH = `COGTB_DEPTH
) (
   // Clock and reset.
   input wire logic clock,
   input wire logic reset_n,
   // Default image load.
   input wire logic load_en,
   input wire logic [DEPTH*8-1:0] load_image,
   // Write port.
   input wire logic wr_en,
   input wire cogtb_pkg::cogtb_idx_t wr_idx,
   input wire logic [7:0] wr_data,
   // Read port.
   input wire logic rd_en,
   input wire cogtb_pkg::cogtb_idx_t rd_idx,
   output logic [7:0] rd_data,
   output logic rd_valid,
   // Whole contents.
   output logic [DEPTH*8-1:0] image
);
   import cogtb_pkg::*;
   logic [7:0] next_rd_data;
   logic next_rd_valid;

   genvar g;
   generate
      for (g = 0; g < DEPTH; g = g + 1) begin : gen_entry
         logic [7:0] next_byte;
         always_comb begin
            next_byte = image[g*8 +: 8];
            if (load_en) begin
               next_byte = load_image[g*8 +: 8];
            end else if (wr_en && (wr_idx == cogtb_idx_t'(g))) begin
               next_byte = wr_data;
            end
         end
         always_ff @(posedge clock or negedge reset_n) begin
            if (!reset_n) begin
               image[g*8 +: 8] <= `COGTB_RESET_BYTE;
            end else begin
               image[g*8 +: 8] <= next_byte;
            end
         end
      end
   endgenerate

   always_comb begin
      next_rd_valid = rd_en;
      next_rd_data = `COGTB_RESET_BYTE;
      if (rd_en && (32'(rd_idx) < DEPTH)) begin
         next_rd_data = image[rd_idx*8 +: 8];
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         rd_data <= `COGTB_RESET_BYTE;
         rd_valid <= 1'b0;
      end else begin
         rd_data <= next_rd_data;
         rd_valid <= next_rd_valid;
      end
   end
endmodule : cogtb_store

// ==== verification/cogtb_host_model.sv ====
// Host model that drives the serial register port of the trim bank.
// Assumes mode 0 framing, one clock domain, and that no offset calibration is running.
`timescale 1ns/1ps
module cogtb_host_model (
   // Clock.
   input wire logic clock,
   // Serial register port.
   output logic spi_sclk,
   output logic spi_cs_n,
   output logic spi_sdi,
   input wire logic spi_sdo,
   input wire logic spi_sdo_oe_n
);
   initial begin
      spi_sclk = 1'b0;
      spi_cs_n = 1'b1;
      spi_sdi = 1'b0;
   end

   // One bit: SDI changes while SCLK is low, and both SCLK phases last eight clocks.
   task automatic bit_io(input logic b, output logic g);
      @(posedge clock);
      spi_sdi <= b;
      repeat (7) @(posedge clock);
      // A read bit is trusted only while the device enables its output.
      g = spi_sdo_oe_n ? 1'bx : spi_sdo;
      spi_sclk <= 1'b1;
      repeat (8) @(posedge clock);
      spi_sclk <= 1'b0;
   endtask : bit_io

   // Callers pass data with the reserved bits cleared.
   // The bench enables no offset calibration, so access is never blocked.
   task automatic frame(input logic rd, input logic [14:0] addr, input int nbytes,
      input logic [15:0] wdata, output logic [15:0] rdata);
      logic [15:0] cmd;
      logic g;
      cmd = {rd, addr};
      rdata = 16'h0000;
      @(posedge clock);
      spi_cs_n <= 1'b0;
      repeat (4) @(posedge clock);
      for (int i = 15; i >= 0; i--) begin
         bit_io(cmd[i], g);
      end
      for (int k = 0; k < nbytes; k++) begin
         for (int b = 7; b >= 0; b--) begin
            bit_io(wdata[8 * k + b], g);
            rdata[8 * k + b] = g;
         end
      end
      repeat (2) @(posedge clock);
      spi_cs_n <= 1'b1;
      // The released data line must not keep looking like the last bit.
      spi_sdi <= ~spi_sdi;
      repeat (8) @(posedge clock);
   endtask : frame
endmodule : cogtb_host_model

// ==== verification/tb_cogtb_bank.sv ====
// Self-checking bench for the trim bank: fuse defaults, random trims, two resets.
// Assumes the design sources, its register header and the host model.
`timescale 1ns/1ps
`include "cogtb_regs.svh"
module tb_cogtb_bank;
   import cogtb_pkg::*;
   logic clock = 1'b0;
   logic reset_n = 1'b0;
   logic core3_input_d_sel = 1'b0;
   logic core2_input_a_sel = 1'b0;
   logic spi_sclk, spi_cs_n, spi_sdi, spi_sdo, spi_sdo_oe_n;
   logic [11:0] fuse_off [4] = '{default: 12'h000};
   logic [4:0] fuse_gain [3] = '{default: 5'h00};
   logic [11:0] core3_offset, core4_offset, core5_offset;
   logic [4:0] core0_gain, core1_gain, core2_gain;
   cogtb_idx_t last_idx;
   logic core2_gain_valid;
   logic [7:0] exp_reg [11];
   logic [15:0] v, rd;
   int r, idx, nb;
   int miscompares = 0;
   int checks_done = 0;

   always #2.5 clock = ~clock;

   cogtb_bank u_dut (
      .clock(clock), .reset_n(reset_n),
      .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi),
      .spi_sdo(spi_sdo), .spi_sdo_oe_n(spi_sdo_oe_n),
      .core3_input_d_sel(core3_input_d_sel), .core2_input_a_sel(core2_input_a_sel),
      .fuse_core3_input_c_offset(fuse_off[0]), .fuse_core3_input_d_offset(fuse_off[1]),
      .fuse_core4_offset(fuse_off[2]), .fuse_core5_offset(fuse_off[3]),
      .fuse_core0_gain(fuse_gain[0]), .fuse_core1_gain(fuse_gain[1]),
      .fuse_core2_input_a_gain(fuse_gain[2]),
      .core3_offset(core3_offset), .core4_offset(core4_offset), .core5_offset(core5_offset),
      .core0_gain(core0_gain), .core1_gain(core1_gain), .core2_gain(core2_gain),
      .last_idx(last_idx), .core2_gain_valid(core2_gain_valid)
   );

   cogtb_host_model u_host (
      .clock(clock), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi),
      .spi_sdo(spi_sdo), .spi_sdo_oe_n(spi_sdo_oe_n)
   );

   function automatic logic [14:0] addr_of(int i);
      if (i < 8) return `COGTB_ADR_CORE3_INPUT_C_OFFSET_TRIM + 15'(i);
      return `COGTB_ADR_CORE0_FINE_GAIN_TRIM + 15'(i - 8);
   endfunction : addr_of

   function automatic logic [15:0] exp_off(int b);
      return {4'h0, exp_reg[b + 1][3:0], exp_reg[b]};
   endfunction : exp_off

   function automatic logic [15:0] exp_gain(int i);
      return {11'h000, exp_reg[i][4:0]};
   endfunction : exp_gain

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] want);
      checks_done++;
      if (seen !== want) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", name, want, seen);
      end
   endtask : check

   task automatic complete_run;
      if (miscompares == 0 && checks_done > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : complete_run

   // New select levels each time, so both inputs of cores 3 and 2 get exercised.
   task automatic check_all;
      logic [15:0] e3, e2;
      @(posedge clock);
      core3_input_d_sel <= 1'($urandom);
      core2_input_a_sel <= 1'($urandom);
      repeat (3) @(posedge clock);
      e3 = core3_input_d_sel ? exp_off(2) : exp_off(0);
      e2 = core2_input_a_sel ? exp_gain(10) : 16'h0000;
      check("core3_offset", {4'h0, core3_offset}, e3);
      check("core4_offset", {4'h0, core4_offset}, exp_off(4));
      check("core5_offset", {4'h0, core5_offset}, exp_off(6));
      check("core0_gain", {11'h000, core0_gain}, exp_gain(8));
      check("core1_gain", {11'h000, core1_gain}, exp_gain(9));
      check("core2_gain", {11'h000, core2_gain}, e2);
      check("core2_gain_valid", {15'h0000, core2_gain_valid}, {15'h0000, core2_input_a_sel & reset_n});
   endtask : check_all

   task automatic reset_with_fuses;
      @(posedge clock);
      reset_n <= 1'b0;
      foreach (fuse_off[i]) fuse_off[i] <= 12'($urandom);
      foreach (fuse_gain[i]) fuse_gain[i] <= 5'($urandom);
      repeat (20) @(posedge clock);
      exp_reg = '{default: 8'h00};
      check_all();
      for (int i = 0; i < 4; i++) begin
         exp_reg[2 * i] = fuse_off[i][7:0];
         exp_reg[2 * i + 1] = {4'h0, fuse_off[i][11:8]};
      end
      for (int i = 0; i < 3; i++) begin
         exp_reg[8 + i] = {3'h0, fuse_gain[i]};
      end
      @(posedge clock);
      reset_n <= 1'b1;
      check_all();
   endtask : reset_with_fuses

   initial begin
      void'($urandom(32'h129e_b7ca));
      for (int pass = 0; pass < 2; pass++) begin
         reset_with_fuses();
         // The first seven writes hit every register, with all ones in the first pass and all zeros in the second.
         for (int n = 0; n < 14; n++) begin
            r = (n < 7) ? n : int'($urandom_range(6, 0));
            v = (n < 7) ? (pass == 0 ? 16'hFFFF : 16'h0000) : 16'($urandom);
            idx = (r < 4) ? 2 * r : r + 4;
            nb = (r < 4) ? 2 : 1;
            v = v & ((r < 4) ? 16'h0FFF : 16'h001F);
            u_host.frame(1'b0, addr_of(idx), nb, v, rd);
            exp_reg[idx] = v[7:0];
            if (nb == 2) exp_reg[idx + 1] = v[15:8];
            check("last_idx", {12'h000, last_idx}, 16'(idx + nb - 1));
            check_all();
         end
         for (int i = 0; i < 11; i++) begin
            u_host.frame(1'b1, addr_of(i), 1, 16'h0000, rd);
            check("readback", rd, {8'h00, exp_reg[i]});
         end
         u_host.frame(1'b1, 15'h0363, 1, 16'h0000, rd);
         check("unmapped", rd, 16'h0000);
      end
      complete_run();
   end

   // A hang counts as a mismatch and still reaches the verdict.
   initial begin
      repeat (60000) @(posedge clock);
      miscompares++;
      complete_run();
   end
endmodule : tb_cogtb_bank
